// >>> cpu_interrupt_recognition_entry_bench.sv
/*
 * bench joining processor end and encoder end; checks stacked frames.
 * assumes the link checker is placed beside the interface here.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_interrupt_recognition_entry_bench;
    import ire_pkg::*;
    logic sys_clk, rst, instr_boundary, prefetch2, trace_pending, cp_mid, sr_wr, vec_fetch, trace_take;
    logic push_valid, push_isp, hold;
    logic [15:0] sr_wr_data, processor_status_word, cur_sr;
    logic [31:0] push_data, vec_addr;
    logic [7:1] src_req, src_autovec, ack_taken, ack_seen;
    logic [7:1][7:0] src_vector;
    logic [32:0] push_q[$];
    int errors = 0, checked = 0, nvec = 0, ntrace = 0;
    // fixed core context
    localparam logic [31:0] VBR = 32'h0000_1000, NPC = 32'h0000_4a00, CPW = 32'hc0de_0001;
    ire_link_if link();
    ire_cpu_end #(.HAS_WAITING_PIN(1'b1)) i_ire_cpu_end (.sys_clk(sys_clk), .rst(rst), .link(link),
        .instr_boundary(instr_boundary), .prefetch2(prefetch2), .trace_pending(trace_pending), .cp_mid(cp_mid),
        .cp_state(CPW), .next_pc(NPC), .vbr(VBR), .sr_wr(sr_wr), .sr_wr_data(sr_wr_data),
        .processor_status_word(processor_status_word), .trace_take(trace_take), .push_valid(push_valid),
        .push_isp(push_isp), .push_data(push_data), .vec_fetch(vec_fetch), .vec_addr(vec_addr));
    ire_irq_encoder i_ire_irq_encoder (.sys_clk(sys_clk), .rst(rst), .link(link), .src_req(src_req),
        .src_autovec(src_autovec), .src_vec_init(7'h7e), .src_vector(src_vector), .ack_taken(ack_taken));
    ire_link_chk i_ire_link_chk (.sys_clk(sys_clk), .rst(rst), .irq_level_in(link.irq_level_in),
        .irq_waiting_out(link.irq_waiting_out), .ack_req(link.ack_req), .first_bus_state(link.first_bus_state),
        .ack_level(link.ack_level), .ack_done(link.ack_done), .vector_num(link.vector_num),
        .auto_vector_req(link.auto_vector_req), .bus_error(link.bus_error));
    // 200 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // record stacked words, vector fetches, acknowledges, trace takes
    always @(posedge sys_clk)
    begin
        if (push_valid) push_q.push_back({push_isp, push_data});
        if (vec_fetch) nvec++;
        if (trace_take) ntrace++;
        ack_seen = ack_seen | ack_taken;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic strobe(input bit pf);
        @(posedge sys_clk);
        if (pf) prefetch2 <= 1'b1;
        else instr_boundary <= 1'b1;
        @(posedge sys_clk);
        prefetch2 <= 1'b0;
        instr_boundary <= 1'b0;
    endtask : strobe
    task automatic set_sr(input logic [15:0] v);
        @(posedge sys_clk);
        sr_wr <= 1'b1;
        sr_wr_data <= v;
        @(posedge sys_clk);
        sr_wr <= 1'b0;
        cur_sr = v;
        @(negedge sys_clk);
        chk(processor_status_word, v);
    endtask : set_sr
    task automatic req(input int l, input logic on);
        @(posedge sys_clk);
        src_req[l] <= on;
    endtask : req
    task automatic wait_pend;
        repeat (20)
        begin
            @(negedge sys_clk);
            if (link.irq_waiting_out === 1'b1) return;
        end
        chk(link.irq_waiting_out, 1'b1);
        print_verdict();
    endtask : wait_pend
    task automatic no_wait(input int n);
        int bad;
        bad = 0;
        repeat (n)
        begin
            @(negedge sys_clk);
            if (link.irq_waiting_out !== 1'b0) bad++;
        end
        chk(33'(bad), 33'h0);
    endtask : no_wait
    // one entry: pend, strobe, collect frame, check vector and status
    task automatic enter(input bit pf, input logic [2:0] lvl, input logic [7:0] vec, input logic src_on);
        logic [32:0] e[$];
        logic [11:0] off;
        logic [15:0] s;
        logic ext;
        int n;
        off = {2'h0, vec, 2'h0};
        ext = !cur_sr[SR_M];
        s = cur_sr;
        push_q.delete();
        ack_seen = 7'h0;
        n = nvec;
        wait_pend();
        strobe(pf);
        repeat (40)
        begin
            @(negedge sys_clk);
            if (nvec != n) break;
        end
        chk(nvec != n, 1'b1);
        if (nvec == n) print_verdict();
        if (cp_mid) e.push_back({ext, CPW});
        e.push_back({ext, NPC});
        e.push_back({ext, 16'h0, s});
        e.push_back({ext, 16'h0, cp_mid ? FMT_CP_MID : FMT_NORMAL, off});
        if (!ext)
        begin
            e.push_back({1'b1, NPC});
            e.push_back({1'b1, 16'h0, s | 16'h2000});
            e.push_back({1'b1, 16'h0, FMT_THROWAWAY, off});
        end
        chk(33'(push_q.size()), 33'(e.size()));
        foreach (e[i]) chk(push_q[i], e[i]);
        chk(vec_addr, VBR + {22'h0, vec, 2'h0});
        chk(ack_seen[lvl], src_on);
        s[15:14] = 2'h0;
        s[SR_S] = 1'b1;
        s[SR_M] = 1'b0;
        s[10:8] = lvl;
        chk(processor_status_word, s);
        cur_sr = s;
        @(posedge sys_clk);
        if (!hold) src_req <= src_req & ~ack_seen;
        // let a dropped level clear the synchroniser before any mask change
        repeat (5) @(posedge sys_clk);
    endtask : enter
    initial
    begin
        int t0, v0;
        rst = 1'b1;
        instr_boundary = 1'b0;
        prefetch2 = 1'b0;
        trace_pending = 1'b0;
        cp_mid = 1'b0;
        sr_wr = 1'b0;
        sr_wr_data = 16'h0;
        src_req = 7'h0;
        src_autovec = 7'h0;
        hold = 1'b0;
        ack_seen = 7'h0;
        for (int l = 1; l < 8; l++) src_vector[l] = 8'h40 + 8'(l);
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        for (int l = 1; l < 8; l++)
        begin
            set_sr(16'h2000);
            req(l, 1'b1);
            src_autovec[l] <= 1'b1;
            enter(1'b0, 3'(l), VEC_AUTO_BASE + 8'(l), 1'b1);
            strobe(1'b1);
        end
        src_autovec <= 7'h0;
        $display("test autovector done");
        set_sr(16'h2000);
        req(1, 1'b1);
        enter(1'b0, 3'h1, VEC_UNINIT, 1'b1);
        strobe(1'b1);
        set_sr(16'h2400);
        req(4, 1'b1);
        no_wait(12);
        set_sr(16'h2300);
        enter(1'b0, 3'h4, 8'h44, 1'b1);
        strobe(1'b1);
        $display("test mask done");
        set_sr(16'h2000);
        req(2, 1'b1);
        wait_pend();
        req(2, 1'b0);
        enter(1'b0, 3'h2, VEC_SPURIOUS, 1'b0);
        strobe(1'b1);
        set_sr(16'h3000);
        req(6, 1'b1);
        enter(1'b0, 3'h6, 8'h46, 1'b1);
        strobe(1'b1);
        cp_mid <= 1'b1;
        set_sr(16'h2000);
        req(3, 1'b1);
        enter(1'b0, 3'h3, 8'h43, 1'b1);
        cp_mid <= 1'b0;
        strobe(1'b1);
        $display("test frames done");
        set_sr(16'h2000);
        req(2, 1'b1);
        enter(1'b0, 3'h2, 8'h42, 1'b1);
        req(5, 1'b1);
        enter(1'b1, 3'h5, 8'h45, 1'b1);
        strobe(1'b1);
        set_sr(16'h2000);
        req(3, 1'b1);
        trace_pending <= 1'b1;
        wait_pend();
        t0 = ntrace;
        v0 = nvec;
        strobe(1'b0);
        repeat (8) @(negedge sys_clk);
        chk(33'(ntrace - t0), 33'h1);
        chk(33'(nvec - v0), 33'h0);
        @(posedge sys_clk);
        trace_pending <= 1'b0;
        enter(1'b0, 3'h3, 8'h43, 1'b1);
        strobe(1'b1);
        $display("test ordering done");
        set_sr(16'h2600);
        req(6, 1'b1);
        no_wait(10);
        req(6, 1'b0);
        set_sr(16'h2700);
        hold = 1'b1;
        req(7, 1'b1);
        enter(1'b0, 3'h7, 8'h47, 1'b1);
        strobe(1'b1);
        no_wait(10);
        set_sr(16'h2600);
        enter(1'b0, 3'h7, 8'h47, 1'b1);
        hold = 1'b0;
        req(7, 1'b0);
        strobe(1'b1);
        repeat (6) @(posedge sys_clk);
        req(7, 1'b1);
        enter(1'b0, 3'h7, 8'h47, 1'b1);
        strobe(1'b1);
        $display("test level seven done");
        set_sr(16'h2000);
        req(4, 1'b1);
        wait_pend();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(link.irq_waiting_out, 1'b0);
        chk(processor_status_word, SR_RESET);
        @(posedge sys_clk);
        rst <= 1'b0;
        cur_sr = SR_RESET;
        no_wait(8);
        req(4, 1'b0);
        $display("test reset done");
        print_verdict();
    end
endmodule : cpu_interrupt_recognition_entry_bench
`default_nettype wire

// >>> ire_cpu_end.sv
/*
 * processor end: recognises prioritised interrupt levels, raises the
 * pending output, runs the acknowledge, stacks context and hands the
 * vector address to the core.
 * assumes the core pulses instr_boundary once per instruction and
 * prefetch2 at the second prefetch after entry, and drains push_* at
 * one word per cycle.
 */
//
// What this block does
// - three-bit level, zero none, seven highest
// - accept level seen on two samples
// - requester holds level until acknowledged
// - shared-level devices hold until own acknowledge
// - pending only when level exceeds mask
// - level seven edge-triggered, ignores mask
// - masks six and seven differ only there
// - lowering mask re-recognises held level
// - assert pending output when request pending
// - check pending per instruction and prefetch
// - drop pending at acknowledge first state
// - build option removes pending output
// - entry saves status, supervisor, no trace, mask
// - acknowledge drives serviced level on address
// - autovector gives twenty-four plus level
// - bus error gives spurious vector 24
// - push next PC, saved status, offset
// - coprocessor mid-instruction stacks extra state
// - master stack adds format one frame
// - load vector, prefetch, resume in handler
// - uninitialised peripheral returns vector 15
// - trace taken before interrupt
`timescale 1ns/10ps
`default_nettype none
module ire_cpu_end #(
    parameter bit HAS_WAITING_PIN = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    ire_link_if.dev link,
    input wire logic instr_boundary,
    input wire logic prefetch2,
    input wire logic trace_pending,
    input wire logic cp_mid,
    input wire logic [31:0] cp_state,
    input wire logic [31:0] next_pc,
    input wire logic [31:0] vbr,
    input wire logic sr_wr,
    input wire logic [15:0] sr_wr_data,
    output logic [15:0] processor_status_word,
    output logic trace_take,
    output logic push_valid,
    output logic push_isp,
    output logic [31:0] push_data,
    output logic vec_fetch,
    output logic [31:0] vec_addr
);
    import ire_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ENTRY = 6'b000010,
        ST_ACK = 6'b000100,
        ST_STACK = 6'b001000,
        ST_VECTOR = 6'b010000,
        ST_RESUME = 6'b100000
    } ire_state_type;

    ire_state_type state_ff;
    ire_state_type nxt_state;
    logic [2:0] lvl;
    logic [2:0] prev_lvl_ff;
    logic [2:0] pend_lvl_ff;
    logic [2:0] svc_lvl_ff;
    logic waiting_ff;
    logic [15:0] sr_ff;
    logic [15:0] sr_copy_ff;
    logic [7:0] vec_ff;
    logic [2:0] idx_ff;
    logic m_ff;
    logic cp_ff;
    logic ack_req_ff;
    logic first_ff;
    logic waiting_pin_ff;
    logic trace_take_ff;
    logic push_valid_ff;
    logic push_isp_ff;
    logic [31:0] push_data_ff;
    logic vec_fetch_ff;
    logic [31:0] vec_addr_ff;
    logic [31:0] word;

    ire_level_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .lvl_async(link.irq_level_in),
        .lvl_valid(lvl)
    );

    // recognition: comparison against mask, plus rising edge into level 7
    wire [2:0] mask = sr_ff[SR_MASK_HI:SR_MASK_LO];
    wire above_mask = (lvl > mask);
    wire nmi_edge = (lvl == LVL_NMI) && (prev_lvl_ff != LVL_NMI);
    wire pend_now = above_mask | nmi_edge;
    wire nxt_waiting = first_ff ? pend_now : (waiting_ff | pend_now);
    wire take_now = instr_boundary & waiting_ff & ~trace_pending;
    wire trace_first = instr_boundary & waiting_ff & trace_pending;

    // vector selection at the end of the acknowledge
    wire [7:0] auto_vec = VEC_AUTO_BASE + {5'h00, svc_lvl_ff};
    wire [7:0] nxt_vec = link.bus_error ? VEC_SPURIOUS :
        (link.auto_vector_req ? auto_vec : link.vector_num);
    wire [11:0] offset = {2'b00, vec_ff, 2'b00};
    wire [31:0] table_addr = vbr + {22'h000000, vec_ff, 2'b00};

    // frame word order: cp state, pc, sr, format/offset, then throwaway copy
    wire [2:0] idx_first = cp_ff ? IDX_CP : IDX_PC;
    wire [2:0] idx_last = m_ff ? IDX_TFMT : IDX_FMT;
    wire [3:0] fmt_master = cp_ff ? FMT_CP_MID : FMT_NORMAL;
    wire [15:0] sr_forced_s = sr_copy_ff | (16'h0001 << SR_S);

    // entry status: supervisor, tracing off, mask at serviced level, M cleared
    logic [15:0] sr_entry;
    always_comb
    begin
        sr_entry = sr_ff;
        sr_entry[SR_S] = 1'b1;
        sr_entry[SR_T1] = 1'b0;
        sr_entry[SR_T0] = 1'b0;
        sr_entry[SR_M] = 1'b0;
        sr_entry[SR_MASK_HI:SR_MASK_LO] = pend_lvl_ff;
    end

    // word pushed for the current slot
    always_comb
    begin
        case (idx_ff)
            IDX_CP: word = cp_state;
            IDX_PC: word = next_pc;
            IDX_SR: word = {16'h0000, sr_copy_ff};
            IDX_FMT: word = {16'h0000, fmt_master, offset};
            IDX_TPC: word = next_pc;
            IDX_TSR: word = {16'h0000, sr_forced_s};
            IDX_TFMT: word = {16'h0000, FMT_THROWAWAY, offset};
            default: word = 32'h00000000;
        endcase
    end

    // sequencer
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (take_now)
                    nxt_state = ST_ENTRY;
            end
            ST_ENTRY: nxt_state = ST_ACK;
            ST_ACK:
            begin
                if (link.ack_done)
                    nxt_state = ST_STACK;
            end
            ST_STACK:
            begin
                if (idx_ff == idx_last)
                    nxt_state = ST_VECTOR;
            end
            ST_VECTOR: nxt_state = ST_RESUME;
            ST_RESUME:
            begin
                if (prefetch2)
                    nxt_state = waiting_ff ? ST_ENTRY : ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        state_ff <= rst ? ST_IDLE : nxt_state;
    end

    // recognition state
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            prev_lvl_ff <= LVL_NONE;
            waiting_ff <= 1'b0;
            pend_lvl_ff <= LVL_NONE;
        end
        else
        begin
            prev_lvl_ff <= lvl;
            waiting_ff <= nxt_waiting;
            pend_lvl_ff <= pend_now ? lvl : pend_lvl_ff;
        end
    end

    // status word: entry update wins over a software write
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sr_ff <= SR_RESET;
        else if (state_ff == ST_ENTRY)
            sr_ff <= sr_entry;
        else if (sr_wr)
            sr_ff <= sr_wr_data;
    end

    // context captured at entry
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sr_copy_ff <= SR_RESET;
            svc_lvl_ff <= LVL_NONE;
            m_ff <= 1'b0;
            cp_ff <= 1'b0;
        end
        else if (state_ff == ST_ENTRY)
        begin
            sr_copy_ff <= sr_ff;
            svc_lvl_ff <= pend_lvl_ff;
            m_ff <= sr_ff[SR_M];
            cp_ff <= cp_mid;
        end
    end

    // acknowledge cycle outputs
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ack_req_ff <= 1'b0;
            first_ff <= 1'b0;
        end
        else
        begin
            ack_req_ff <= (nxt_state == ST_ACK);
            first_ff <= (state_ff == ST_ENTRY);
        end
    end

    // vector capture and stacking counter
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            vec_ff <= VEC_SPURIOUS;
        else if (state_ff == ST_ACK && link.ack_done)
            vec_ff <= nxt_vec;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            idx_ff <= IDX_PC;
        else if (state_ff == ST_ACK)
            idx_ff <= idx_first;
        else if (state_ff == ST_STACK)
            idx_ff <= idx_ff + 3'h1;
    end

    // stack pushes, vector fetch and trace hand-off
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            push_valid_ff <= 1'b0;
            push_isp_ff <= 1'b0;
            push_data_ff <= 32'h00000000;
            vec_fetch_ff <= 1'b0;
            vec_addr_ff <= 32'h00000000;
            trace_take_ff <= 1'b0;
        end
        else
        begin
            push_valid_ff <= (state_ff == ST_STACK);
            push_isp_ff <= ~m_ff | (idx_ff >= IDX_TPC);
            push_data_ff <= word;
            vec_fetch_ff <= (state_ff == ST_VECTOR);
            vec_addr_ff <= (state_ff == ST_VECTOR) ? table_addr : vec_addr_ff;
            trace_take_ff <= (state_ff == ST_IDLE) & trace_first;
        end
    end

    // pending pin, tied low in the variant without it
    always_ff @(posedge sys_clk)
    begin
        waiting_pin_ff <= rst ? 1'b0 : (HAS_WAITING_PIN & nxt_waiting);
    end

    assign link.irq_waiting_out = waiting_pin_ff;
    assign link.ack_req = ack_req_ff;
    assign link.first_bus_state = first_ff;
    assign link.ack_level = svc_lvl_ff;
    assign processor_status_word = sr_ff;
    assign trace_take = trace_take_ff;
    assign push_valid = push_valid_ff;
    assign push_isp = push_isp_ff;
    assign push_data = push_data_ff;
    assign vec_fetch = vec_fetch_ff;
    assign vec_addr = vec_addr_ff;
endmodule : ire_cpu_end
`default_nettype wire

// >>> ire_irq_encoder.sv
/*
 * requester end: merges per-level requests into an encoded level and
 * answers acknowledge cycles with a vector, an autovector or a bus error.
 * assumes each source holds its request until its ack_taken pulse.
 */
`timescale 1ns/10ps
`default_nettype none
module ire_irq_encoder (
    input wire logic sys_clk,
    input wire logic rst,
    ire_link_if.req link,
    input wire logic [7:1] src_req,
    input wire logic [7:1] src_autovec,
    input wire logic [7:1] src_vec_init,
    input wire logic [7:1][7:0] src_vector,
    output logic [7:1] ack_taken
);
    import ire_pkg::*;

    logic [2:0] enc;
    logic [2:0] level_ff;
    logic done_ff;
    logic [7:0] vec_ff;
    logic auto_vector_req_ff;
    logic berr_ff;
    logic [7:1] taken_ff;

    // highest active source wins
    always_comb
    begin
        enc = LVL_NONE;
        for (int i = 1; i <= 7; i++)
        begin
            if (src_req[i])
                enc = i[2:0];
        end
    end

    wire [2:0] al = link.ack_level;
    wire hit = src_req[al] && (al != LVL_NONE);
    wire [7:0] ans_vec = src_vec_init[al] ? src_vector[al] : VEC_UNINIT;

    // encoded level follows sources, which hold until acknowledged
    always_ff @(posedge sys_clk)
    begin
        level_ff <= rst ? LVL_NONE : enc;
    end

    // one answer per acknowledge, the cycle after its first state
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            done_ff <= 1'b0;
            vec_ff <= VEC_UNINIT;
            auto_vector_req_ff <= 1'b0;
            berr_ff <= 1'b0;
            taken_ff <= 7'h00;
        end
        else
        begin
            done_ff <= link.first_bus_state;
            vec_ff <= ans_vec;
            auto_vector_req_ff <= link.first_bus_state & hit & src_autovec[al];
            berr_ff <= link.first_bus_state & ~hit;
            taken_ff <= (link.first_bus_state & hit) ? (7'h01 << (al - 3'h1)) : 7'h00;
        end
    end

    assign link.irq_level_in = level_ff;
    assign link.ack_done = done_ff;
    assign link.vector_num = vec_ff;
    assign link.auto_vector_req = auto_vector_req_ff;
    assign link.bus_error = berr_ff;
    assign ack_taken = taken_ff;
endmodule : ire_irq_encoder
`default_nettype wire

// >>> ire_level_sync.sv
/*
 * three-flop synchroniser for the request level; a level is accepted
 * once the second and third stages agree on all bits.
 * assumes the level comes from outside the sys_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module ire_level_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ire_pkg::LVL_W-1:0] lvl_async,
    output logic [ire_pkg::LVL_W-1:0] lvl_valid
);
    import ire_pkg::*;

    logic [LVL_W-1:0] s1_ff;
    logic [LVL_W-1:0] s2_ff;
    logic [LVL_W-1:0] s3_ff;
    logic [LVL_W-1:0] valid_ff;
    wire agree = (s2_ff == s3_ff);

    // per-bit shift chain, first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < LVL_W; gi++)
        begin : g_bit
            always_ff @(posedge sys_clk)
            begin
                s1_ff[gi] <= rst ? 1'b0 : lvl_async[gi];
                s2_ff[gi] <= rst ? 1'b0 : s1_ff[gi];
                s3_ff[gi] <= rst ? 1'b0 : s2_ff[gi];
            end
        end
    endgenerate

    // accept only a level seen twice in a row
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            valid_ff <= LVL_NONE;
        else if (agree)
            valid_ff <= s3_ff;
    end

    assign lvl_valid = valid_ff;
endmodule : ire_level_sync
`default_nettype wire

// >>> ire_link_chk.sv
/*
 * link checker: acknowledge handshake and pending output timing.
 * assumes it sits beside the link interface, one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module ire_link_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] irq_level_in,
    input wire logic irq_waiting_out,
    input wire logic ack_req,
    input wire logic first_bus_state,
    input wire logic [2:0] ack_level,
    input wire logic ack_done,
    input wire logic [7:0] vector_num,
    input wire logic auto_vector_req,
    input wire logic bus_error
);
    import ire_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // pending, acknowledge start and answer
    property p_wait_cause;
        $rose(irq_waiting_out) |-> irq_level_in != LVL_NONE && $past(irq_level_in, 2) != LVL_NONE;
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("pending rose without held level");
    property p_ack_start;
        $rose(ack_req) |-> first_bus_state && $past(irq_waiting_out);
    endproperty
    a_ack_start: assert property (p_ack_start) else $error("acknowledge without pending");
    property p_first_pulse;
        first_bus_state |=> !first_bus_state && ack_req;
    endproperty
    a_first_pulse: assert property (p_first_pulse) else $error("first state not one cycle");
    property p_answer;
        first_bus_state |-> ##1 ack_done;
    endproperty
    a_answer: assert property (p_answer) else $error("acknowledge not answered");
    property p_drop;
        first_bus_state && ack_level != LVL_NMI && irq_level_in <= ack_level && $past(irq_level_in, 2) <= ack_level
            && $past(irq_level_in, 4) <= ack_level |=> !irq_waiting_out;
    endproperty
    a_drop: assert property (p_drop) else $error("pending kept after first state");
    property p_lvl_stable;
        ack_req && $past(ack_req) |-> $stable(ack_level);
    endproperty
    a_lvl_stable: assert property (p_lvl_stable) else $error("serviced level moved");
    property p_lvl_nonzero;
        ack_req |-> ack_level != LVL_NONE;
    endproperty
    a_lvl_nonzero: assert property (p_lvl_nonzero) else $error("serviced level zero");
    property p_tags;
        (bus_error || auto_vector_req) |-> ack_done && ack_req;
    endproperty
    a_tags: assert property (p_tags) else $error("answer flag outside acknowledge");
    // main transfer kinds
    c_auto: cover property (first_bus_state ##1 auto_vector_req);
    c_err: cover property (first_bus_state ##1 bus_error);
    c_nmi: cover property (first_bus_state && ack_level == LVL_NMI);
endmodule : ire_link_chk
`default_nettype wire

// >>> ire_link_if.sv
/*
 * link between the processor end and the interrupt encoder end.
 * assumes both ends run on the same sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
interface ire_link_if;
    logic [2:0] irq_level_in;     // encoded request level
    logic irq_waiting_out;        // pending indication
    logic ack_req;                // acknowledge cycle running
    logic first_bus_state;        // first cycle of acknowledge
    logic [2:0] ack_level;        // serviced level on A3..A1
    logic ack_done;               // cycle terminated
    logic [7:0] vector_num;       // device-supplied vector
    logic auto_vector_req;        // use autovector
    logic bus_error;              // spurious termination
    modport dev (
        input irq_level_in, ack_done, vector_num, auto_vector_req, bus_error,
        output irq_waiting_out, ack_req, first_bus_state, ack_level
    );
    modport req (
        output irq_level_in, ack_done, vector_num, auto_vector_req, bus_error,
        input irq_waiting_out, ack_req, first_bus_state, ack_level
    );
endinterface : ire_link_if
`default_nettype wire

// >>> ire_pkg.sv
/*
 * constants shared by both ends of the interrupt recognition and entry link:
 * level codes, vector numbers, status word layout, frame formats.
 * assumes a single 200 MHz clock and nothing else.
 */
package ire_pkg;
    localparam int LVL_W = 3;
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_NMI = 3'h7;
    localparam int VEC_W = 8;
    localparam logic [7:0] VEC_SPURIOUS = 8'h18;   // 24
    localparam logic [7:0] VEC_AUTO_BASE = 8'h18;  // autovector = base + level
    localparam logic [7:0] VEC_UNINIT = 8'h0f;     // 15
    localparam int VEC_SHIFT = 2;                  // one longword per entry
    localparam int SR_T1 = 15;                     // trace_ctl_hi
    localparam int SR_T0 = 14;                     // trace_ctl_lo
    localparam int SR_S = 13;
    localparam int SR_M = 12;
    localparam int SR_MASK_HI = 10;
    localparam int SR_MASK_LO = 8;
    localparam logic [15:0] SR_RESET = 16'h2700;
    localparam logic [3:0] FMT_NORMAL = 4'h0;
    localparam logic [3:0] FMT_THROWAWAY = 4'h1;
    localparam logic [3:0] FMT_CP_MID = 4'h9;
    localparam logic [2:0] IDX_CP = 3'h0;          // frame word slots
    localparam logic [2:0] IDX_PC = 3'h1;
    localparam logic [2:0] IDX_SR = 3'h2;
    localparam logic [2:0] IDX_FMT = 3'h3;
    localparam logic [2:0] IDX_TPC = 3'h4;
    localparam logic [2:0] IDX_TSR = 3'h5;
    localparam logic [2:0] IDX_TFMT = 3'h6;
endpackage : ire_pkg
